// file: rtl/mss_seq.sv
// Purpose: move execution and stop handling for a servo indexer
// Assumes: host command fields held stable; start and control pulses last one cycle
// Notes:   step rate is produced as an accumulator carry, one step pulse per carry while jogging or steps remain
`default_nettype none
module mss_seq
  import mss_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input  wire logic               clk_sys,
  input  wire logic               rst,
  input  wire logic               ce,
  input  wire logic               start,
  input  wire mss_cmd_t           cmd,
  input  wire logic               jog_cw,
  input  wire logic               jog_active,
  input  wire logic [POS_W-1:0]   target,
  input  wire mss_prof_t          prof,
  input  wire logic               hold_cmd,
  input  wire logic               resume_cmd,
  input  wire logic               istop_cmd,
  input  wire logic               reset_errors,
  input  wire logic [RATE_W-1:0]  istop_rate,
  input  wire logic               jog_stop_in,
  input  wire logic               limit_cw,
  input  wire logic               limit_ccw,
  input  wire logic               estop_in,
  input  wire logic               stall,
  input  wire logic               pos_err_over,
  output logic [POS_W-1:0]        pos_q,
  output logic                    step_q,
  output logic                    refused_q,
  output mss_stat_t               stat_q
);
  mss_state_t        st_q;
  mss_cmd_t          mode_q;
  mss_prof_t         prof_q;
  logic              dir_q;
  logic [POS_W:0]    left_q;
  logic [POS_W-1:0]  tgt_q;
  logic              err_q;
  logic              jstop_d1_q;
  logic              estop_d1_q;
  logic              hold_stop_q;
  logic              istop_src_q;
  logic [DIV_W-1:0]  div_q;
  logic              tick;
  logic [SPD_W:0]    acc_q;
  logic [SPD_W-1:0]  speed;
  logic [SPD_W-1:0]  ramp_tgt;
  logic [RATE_W-1:0] dn_rate;
  logic              halt;
  logic              step_now;
  logic              jstop_edge;
  logic              estop_edge;
  logic              lim_hit;
  logic              start_ok;
  logic [POS_W:0]    abs_diff;
  logic [POS_W:0]    dec_dist;
  logic              go_istop;
  logic              err_set;
  logic              finish;
  logic [POS_W-1:0]  res_diff;
  localparam int     TICKS_PER_S = CLK_HZ / TICK_CYCLES;

  // millisecond tick
  assign tick = (div_q == DIV_W'(TICK_CYCLES - 1));
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div_q <= '0;
    end else if (ce) begin
      div_q <= tick ? '0 : div_q + 1'b1;
    end
  end

  assign jstop_edge = jog_stop_in & ~jstop_d1_q;
  assign estop_edge = estop_in & ~estop_d1_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      jstop_d1_q <= 1'b0;
      estop_d1_q <= 1'b0;
    end else if (ce) begin
      jstop_d1_q <= jog_stop_in;
      estop_d1_q <= estop_in;
    end
  end

  // limit facing the direction of travel
  assign lim_hit = dir_q ? limit_cw : limit_ccw;
  assign go_istop = istop_cmd | estop_edge | (lim_hit & mode_q != MSS_CMD_JOG); // [R7] [R8]

  // stop error latch; a new stop event wins over a coincident clear
  assign err_set = ((st_q == MSS_RUN) || (st_q == MSS_CSTOP)) &&
                   (estop_edge || (lim_hit && (mode_q != MSS_CMD_JOG))); // [R9]
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      err_q <= 1'b0;
    end else if (ce) begin
      if (err_set) begin
        err_q <= 1'b1; // [R8] [R9]
      end else if (reset_errors) begin
        err_q <= 1'b0;
      end
    end
  end

  refuse_err_a: assert property (@(posedge clk_sys) disable iff (rst) (ce && start && err_q) |=> refused_q) // [R9]
    else $error("start not refused while stop error latched");
  estop_latch_a: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && ((st_q == MSS_RUN) || (st_q == MSS_CSTOP)) && estop_edge) |=> (st_q == MSS_ISTOP && err_q)) // [R8] [R9]
    else $error("emergency edge did not give a latched immediate stop");
  lim_istop_a: assert property (@(posedge clk_sys) disable iff (rst) // [R7]
    (ce && st_q == MSS_RUN && lim_hit && mode_q != MSS_CMD_JOG) |=> (st_q == MSS_ISTOP))
    else $error("limit during move did not give an immediate stop");

  // start gating: latched error refuses, jog on a limit allowed only moving away
  always_comb begin
    start_ok = !err_q && (st_q == MSS_IDLE || st_q == MSS_HELD); // [R9] [R13]
    if (cmd == MSS_CMD_JOG && (jog_cw ? limit_cw : limit_ccw)) begin
      start_ok = 1'b0; // [R20]
    end
    if (cmd == MSS_CMD_NONE) begin
      start_ok = 1'b0;
    end
  end

  // signed distance for absolute moves
  assign abs_diff = {target[POS_W-1], target} - {pos_q[POS_W-1], pos_q}; // [R14]

  // remaining signed distance of a held move to its kept target
  assign res_diff = tgt_q - pos_q; // [R12]

  // steps needed to stop: v*v/(2*a*TICKS_PER_S)
  always_comb begin
    dec_dist = '0;
    if (prof_q.decel != '0) begin
      dec_dist = (POS_W+1)'((64'(speed) * 64'(speed)) / (64'(prof_q.decel) * 64'(TICKS_PER_S) * 64'd2));
    end
  end

  // ramp target and rate per state
  always_comb begin
    ramp_tgt = prof_q.speed;
    dn_rate  = prof_q.decel;
    halt     = 1'b0;
    case (st_q)
      MSS_RUN: begin
        if (mode_q != MSS_CMD_JOG && left_q <= dec_dist) begin
          ramp_tgt = SPD_ZERO; // [R16]
        end
      end
      MSS_CSTOP: ramp_tgt = SPD_ZERO; // [R1]
      MSS_ISTOP: begin
        ramp_tgt = SPD_ZERO;
        dn_rate  = istop_rate; // [R2]
        halt     = (istop_rate < ISTOP_RATE_MIN); // [R2] [R21]
      end
      MSS_IDLE, MSS_HELD, MSS_FAULT: begin
        ramp_tgt = SPD_ZERO;
        halt     = 1'b1;
      end
      default: begin
        ramp_tgt = SPD_ZERO;
        halt     = 1'b1;
      end
    endcase
  end

  mss_ramp u_ramp (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .tick    (tick),
    .halt    (halt),
    .target  (ramp_tgt),
    .up_rate (prof_q.accel),
    .dn_rate (dn_rate),
    .speed_q (speed)
  );

  // step generator: carry of a speed accumulator at clock rate
  logic [SPD_W:0] acc_sum;
  assign acc_sum  = acc_q + {1'b0, speed};
  assign step_now = (acc_sum >= (SPD_W+1)'(CLK_HZ)) && (mode_q == MSS_CMD_JOG || left_q != '0);
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      acc_q  <= '0;
      step_q <= 1'b0;
    end else if (ce) begin
      step_q <= step_now;
      acc_q  <= (acc_sum >= (SPD_W+1)'(CLK_HZ)) ? acc_sum - (SPD_W+1)'(CLK_HZ) : acc_sum;
    end
  end

  // profile position, wraps naturally at the signed ends
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pos_q <= '0;
    end else if (ce && step_now) begin
      pos_q <= dir_q ? pos_q + 1'b1 : pos_q - 1'b1; // [R17] [R22]
    end
  end

  // main sequencer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q        <= MSS_IDLE;
      mode_q      <= MSS_CMD_NONE;
      prof_q      <= '0;
      dir_q       <= 1'b1;
      left_q      <= '0;
      tgt_q       <= '0;
      hold_stop_q <= 1'b0;
      istop_src_q <= 1'b0;
      refused_q   <= 1'b0;
    end else if (ce) begin
      refused_q <= start & ~start_ok;
      if (step_now && left_q != '0) begin
        left_q <= left_q - 1'b1;
      end
      case (st_q)
        MSS_IDLE, MSS_HELD: begin
          if (start && start_ok) begin
            st_q        <= MSS_RUN; // [R13]
            mode_q      <= cmd;
            prof_q      <= prof;
            hold_stop_q <= 1'b0;
            case (cmd)
              MSS_CMD_REL: begin
                dir_q  <= ~target[POS_W-1]; // [R10]
                left_q <= target[POS_W-1] ? (POS_W+1)'(-{target[POS_W-1], target})
                                          : {1'b0, target};
                tgt_q  <= pos_q + target;
              end
              MSS_CMD_ABS: begin
                dir_q  <= ~abs_diff[POS_W]; // [R15]
                left_q <= abs_diff[POS_W] ? -abs_diff : abs_diff;
                tgt_q  <= target;
              end
              default: begin
                dir_q  <= jog_cw; // [R17]
                left_q <= '0;
              end
            endcase
          end else if (st_q == MSS_HELD && resume_cmd && !err_q) begin
            st_q   <= MSS_RUN;
            prof_q <= prof; // [R12]
            dir_q  <= ~res_diff[POS_W-1];
            left_q <= res_diff[POS_W-1] ? {1'b0, -res_diff} : {1'b0, res_diff};
          end
        end
        MSS_RUN: begin
          if (go_istop) begin
            st_q        <= MSS_ISTOP;
            istop_src_q <= ~lim_hit | istop_cmd | estop_edge;
          end else if (hold_cmd && mode_q != MSS_CMD_JOG) begin
            st_q        <= MSS_CSTOP; // [R5] [R11]
            hold_stop_q <= 1'b1;
          end else if (mode_q == MSS_CMD_JOG && (!jog_active || jstop_edge)) begin
            st_q <= MSS_CSTOP; // [R6]
          end else if (mode_q != MSS_CMD_JOG && left_q == '0 && speed == SPD_ZERO) begin
            st_q <= MSS_IDLE; // [R23]
          end else if (mode_q == MSS_CMD_JOG) begin
            prof_q <= prof; // [R18] [R19]
          end
        end
        MSS_CSTOP: begin
          if (go_istop) begin
            st_q        <= MSS_ISTOP;
            istop_src_q <= ~lim_hit | istop_cmd | estop_edge;
          end else if (speed == SPD_ZERO) begin
            st_q <= hold_stop_q ? MSS_HELD : MSS_IDLE; // [R11]
          end
        end
        MSS_ISTOP: begin
          if ((istop_src_q && stall) || pos_err_over) begin
            st_q <= MSS_FAULT; // [R3] [R4]
          end else if (speed == SPD_ZERO) begin
            st_q   <= MSS_IDLE; // [R8]
            left_q <= '0;
          end
        end
        MSS_FAULT: begin
          if (reset_errors) begin
            st_q <= MSS_IDLE;
          end
        end
        default: st_q <= MSS_IDLE;
      endcase
    end
  end

  sequence hold_req_s;
    ce && st_q == MSS_RUN && hold_cmd && !go_istop && mode_q != MSS_CMD_JOG;
  endsequence
  sequence cstop_s;
    st_q == MSS_CSTOP && hold_stop_q;
  endsequence
  sequence start_rel_s;
    ce && st_q == MSS_IDLE && start && start_ok && cmd == MSS_CMD_REL;
  endsequence

  hold_cstop_a: assert property (@(posedge clk_sys) disable iff (rst) hold_req_s |=> cstop_s) // [R5] [R11]
    else $error("hold did not start a controlled stop");
  rel_dir_a: assert property (@(posedge clk_sys) disable iff (rst) // [R10]
    start_rel_s |=> (dir_q == !$past(target[POS_W-1])))
    else $error("relative move direction does not follow offset sign");
  istop_halt_a: assert property (@(posedge clk_sys) disable iff (rst) // [R2]
    (ce && st_q == MSS_ISTOP && istop_rate < ISTOP_RATE_MIN) |=> (speed == SPD_ZERO))
    else $error("zero immediate-stop rate did not halt at once");
  stall_fault_a: assert property (@(posedge clk_sys) disable iff (rst) // [R4]
    (ce && st_q == MSS_ISTOP && istop_src_q && stall) |=> (st_q == MSS_FAULT))
    else $error("stall during immediate stop did not fault");

  // completion of a positioned move without any stop request
  assign finish = (st_q == MSS_RUN) && (mode_q != MSS_CMD_JOG) && !go_istop && !hold_cmd &&
                  (left_q == '0) && (speed == SPD_ZERO); // [R23]

  // status word returned to the host
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stat_q <= '{moving: 1'b0, cw: 1'b1, held: 1'b0, latched_err: 1'b0,
                  pos_invalid: 1'b0, motor_en: 1'b1, done: 1'b0};
    end else if (ce) begin
      stat_q.moving      <= (st_q == MSS_RUN) || (st_q == MSS_CSTOP) || (st_q == MSS_ISTOP);
      stat_q.cw          <= dir_q;
      stat_q.held        <= (st_q == MSS_HELD); // [R11] [R23]
      stat_q.latched_err <= err_q; // [R9]
      stat_q.pos_invalid <= (st_q == MSS_FAULT); // [R3] [R4]
      stat_q.motor_en    <= (st_q != MSS_FAULT); // [R3] [R4]
      stat_q.done        <= finish | (stat_q.done & ~(start & start_ok));
    end
  end

  fault_stat_a: assert property (@(posedge clk_sys) disable iff (rst) // [R3]
    (ce && st_q == MSS_FAULT) |=> (!stat_q.motor_en && stat_q.pos_invalid))
    else $error("fault state did not disable motor");
  held_flag_a: assert property (@(posedge clk_sys) disable iff (rst) (ce && st_q == MSS_HELD) |=> stat_q.held) // [R11]
    else $error("held move not flagged");
endmodule
`default_nettype wire

// file: rtl/mss_pkg.sv
// Purpose: constants and types for the move and stop sequencer
// Assumes: one motion clock, host command bits sampled synchronously
// Notes:   speeds in steps/s, rates in steps/s/ms
// How it works
// [R1] controlled stop ramps down at the move's own deceleration; position stays valid
// [R2] immediate stop ramps at its own rate; zero rate halts at once
// [R3] position error over limit during immediate stop disables motor, raises fault
// [R4] host or emergency immediate stop with stall disables motor, raises fault
// [R5] host hold brings supported moves to controlled stop; resume or abandon
// [R6] jog-stop input edge stops only jog moves; others ignore it
// [R7] limit input during non-jog move causes immediate stop
// [R8] emergency input gives immediate stop; interrupted move cannot restart
// [R9] after emergency or limit stop, moves refused until reset-errors command
// [R10] relative target is signed offset; positive clockwise, negative counter-clockwise
// [R11] hold on relative or absolute move sets held flag once stopped
// [R12] resume applies new speed and rates, keeps original target
// [R13] new move while held abandons the held move
// [R14] absolute move derives direction and distance from profile position
// [R15] absolute move clockwise above position, counter-clockwise below
// [R16] relative and absolute moves ramp trapezoid or triangle by distance
// [R17] jog runs while command active; clockwise counts up, counter-clockwise down
// [R18] jog accelerates to programmed speed then holds it
// [R19] jog takes new speed and rates on the fly without stopping
// [R20] jog may start on active limit only when moving away from it
// [R21] immediate-stop rate defaults zero; 1500 to 15999 selects a ramp
// [R22] profile position wraps at ends of signed 31-bit range
// [R23] reaching target without stop request completes and clears held flag
`default_nettype none
package mss_pkg;
  localparam int POS_W     = 31;
  localparam int SPD_W     = 24;
  localparam int RATE_W    = 16;
  localparam int CLK_HZ    = 10_000_000;
  localparam int TICK_US   = 1000;
  localparam int TICK_CYC  = CLK_HZ / 1_000_000 * TICK_US;
  localparam int DIV_W     = 16;
  localparam logic [RATE_W-1:0] ISTOP_RATE_RST = 16'h0000;
  localparam logic [RATE_W-1:0] ISTOP_RATE_MIN = 16'h05DC;
  localparam logic [RATE_W-1:0] ISTOP_RATE_MAX = 16'h3E7F;
  localparam logic [SPD_W-1:0]  SPD_ZERO       = 24'h000000;

  typedef enum logic [2:0] {
    MSS_CMD_NONE = 3'h0,
    MSS_CMD_REL  = 3'h1,
    MSS_CMD_ABS  = 3'h2,
    MSS_CMD_JOG  = 3'h3
  } mss_cmd_t;

  typedef enum logic [5:0] {
    MSS_IDLE  = 6'b000001,
    MSS_RUN   = 6'b000010,
    MSS_CSTOP = 6'b000100,
    MSS_ISTOP = 6'b001000,
    MSS_HELD  = 6'b010000,
    MSS_FAULT = 6'b100000
  } mss_state_t;

  typedef struct packed {
    logic [SPD_W-1:0]  speed;
    logic [RATE_W-1:0] accel;
    logic [RATE_W-1:0] decel;
  } mss_prof_t;

  typedef struct packed {
    logic moving;
    logic cw;
    logic held;
    logic latched_err;
    logic pos_invalid;
    logic motor_en;
    logic done;
  } mss_stat_t;
endpackage
`default_nettype wire

// file: rtl/mss_ramp.sv
// Purpose: velocity ramp toward a target speed at given rates
// Assumes: tick pulses once per millisecond
// Notes:   rates are steps/s per tick
`default_nettype none
module mss_ramp
  import mss_pkg::*;
#(
  parameter int SW = SPD_W,
  parameter int RW = RATE_W
) (
  input  wire logic          clk_sys,
  input  wire logic          rst,
  input  wire logic          ce,
  input  wire logic          tick,
  input  wire logic          halt,
  input  wire logic [SW-1:0] target,
  input  wire logic [RW-1:0] up_rate,
  input  wire logic [RW-1:0] dn_rate,
  output logic      [SW-1:0] speed_q
);
  logic [SW:0] up_sum;
  assign up_sum = {1'b0, speed_q} + {{(SW-RW+1){1'b0}}, up_rate};

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      speed_q <= '0;
    end else if (ce) begin
      if (halt) begin
        speed_q <= '0;
      end else if (tick) begin
        if (speed_q < target) begin
          speed_q <= (up_sum[SW-1:0] > target || up_sum[SW]) ? target : up_sum[SW-1:0];
        end else if (speed_q > target) begin
          speed_q <= (speed_q - target > {{(SW-RW){1'b0}}, dn_rate}) ?
                     speed_q - SW'(dn_rate) : target;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: bench/mss_host_model.sv
// Purpose: host model sending one-cycle command pulses
// Assumes: bench sets command fields before a pulse
// Notes:   mask order start, hold, resume, istop, reset-errors
`default_nettype none
module mss_host_model (
  input  wire logic clk_sys,
  output logic      start,
  output logic      hold_cmd,
  output logic      resume_cmd,
  output logic      istop_cmd,
  output logic      reset_errors
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {start, hold_cmd, resume_cmd, istop_cmd, reset_errors} = 5'h00;
  task automatic send(input logic [4:0] m);
    @(posedge clk_sys);
    {start, hold_cmd, resume_cmd, istop_cmd, reset_errors} <= m;
    @(posedge clk_sys);
    {start, hold_cmd, resume_cmd, istop_cmd, reset_errors} <= 5'h00;
  endtask
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// Purpose: self-checking bench for the move and stop sequencer
// Assumes: ramp tick shortened to a few cycles
// Notes:   moves are judged by final position and status bits
`default_nettype none
module tb_top
  import mss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [4:0] GO = 5'h10, HLD = 5'h08, RES = 5'h04, IST = 5'h02, CLR = 5'h01;
  logic clk_sys, rst, start, hold_cmd, resume_cmd, istop_cmd, reset_errors, step_q, refused_q, seen;
  logic jog_cw, jog_active, jog_stop_in, limit_cw, limit_ccw, estop_in, stall, pos_err_over;
  logic [POS_W-1:0]  target, pos_q, p0;
  logic [RATE_W-1:0] istop_rate;
  mss_cmd_t          cmd;
  mss_prof_t         prof;
  mss_stat_t         stat_q;
  int                n_mismatch, compares, cyc, n_step, n0;
  mss_seq #(.TICK_CYCLES(4)) dut_u (.clk_sys(clk_sys), .rst(rst), .ce(1'b1), .start(start), .cmd(cmd),
    .jog_cw(jog_cw), .jog_active(jog_active), .target(target), .prof(prof), .hold_cmd(hold_cmd),
    .resume_cmd(resume_cmd), .istop_cmd(istop_cmd), .reset_errors(reset_errors), .istop_rate(istop_rate),
    .jog_stop_in(jog_stop_in), .limit_cw(limit_cw), .limit_ccw(limit_ccw), .estop_in(estop_in),
    .stall(stall), .pos_err_over(pos_err_over), .pos_q(pos_q), .step_q(step_q), .refused_q(refused_q),
    .stat_q(stat_q));
  mss_host_model host_u (.clk_sys(clk_sys), .start(start), .hold_cmd(hold_cmd), .resume_cmd(resume_cmd),
    .istop_cmd(istop_cmd), .reset_errors(reset_errors));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic complete_run;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    n_step <= n_step + int'(step_q);
    if (cyc == 95000) begin
      n_mismatch++;
      complete_run();
    end
  end
  task automatic chk_bit(input logic g, input logic e, input string m);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR t=%0t %s got %b", $time, m, g);
    end
  endtask
  task automatic chk_pos(input logic [POS_W-1:0] g, input logic [POS_W-1:0] e, input string m);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic wait_mv(input logic v, input int lim);
    int i;
    i = 0;
    while (stat_q.moving !== v && i < lim) begin
      @(negedge clk_sys);
      i++;
    end
  endtask
  task automatic move(input mss_cmd_t c, input logic [POS_W-1:0] t);
    @(posedge clk_sys);
    cmd <= c;
    target <= t;
    host_u.send(GO);
    wait_mv(1'b1, 20);
  endtask
  task automatic try_ref(input mss_cmd_t c);
    @(posedge clk_sys);
    cmd <= c;
    host_u.send(GO);
    seen = 1'b0;
    repeat (6) begin
      @(negedge clk_sys);
      seen = seen | refused_q;
    end
  endtask
  task automatic do_reset;
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    cycles(2);
  endtask
  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask
  initial begin
    n_mismatch = 0;
    compares = 0;
    cyc = 0;
    n_step = 0;
    {jog_cw, jog_active, jog_stop_in, limit_cw, limit_ccw, estop_in, stall, pos_err_over} = 8'h00;
    cmd = MSS_CMD_NONE;
    target = '0;
    istop_rate = ISTOP_RATE_RST;
    prof = '{speed: 24'h0F4240, accel: 16'h2000, decel: 16'h2000};
    rst = 1'b1;
    do_reset();
    chk_pos(pos_q, 31'h00000000, "reset pos");
    n0 = n_step;
    move(MSS_CMD_REL, 31'h000000C8);
    chk_bit(stat_q.cw, 1'b1, "rel fwd dir");
    wait_mv(1'b0, 20000);
    chk_pos(pos_q, 31'h000000C8, "rel fwd end");
    chk_pos(POS_W'(n_step - n0), 31'h000000C8, "step count");
    chk_bit(stat_q.done, 1'b1, "done flag");
    move(MSS_CMD_REL, 31'h7FFFFF9C);
    chk_bit(stat_q.cw, 1'b0, "rel back dir");
    wait_mv(1'b0, 20000);
    chk_pos(pos_q, 31'h00000064, "rel back end");
    move(MSS_CMD_ABS, 31'h7FFFFFCE);
    chk_bit(stat_q.cw, 1'b0, "abs down dir");
    wait_mv(1'b0, 20000);
    chk_pos(pos_q, 31'h7FFFFFCE, "abs down end");
    move(MSS_CMD_ABS, 31'h00000032);
    chk_bit(stat_q.cw, 1'b1, "abs up dir");
    wait_mv(1'b0, 20000);
    chk_pos(pos_q, 31'h00000032, "abs up end");
    tdone("moves");
    move(MSS_CMD_ABS, 31'h000003E8);
    cycles(2000);
    host_u.send(HLD);
    wait_mv(1'b0, 8000);
    chk_bit(stat_q.held, 1'b1, "held flag");
    chk_bit(pos_q != 31'h000003E8, 1'b1, "held short");
    prof <= '{speed: 24'h07A120, accel: 16'h1000, decel: 16'h1000};
    host_u.send(RES);
    wait_mv(1'b1, 20);
    wait_mv(1'b0, 30000);
    chk_pos(pos_q, 31'h000003E8, "resume end");
    chk_bit(stat_q.held, 1'b0, "held clear");
    move(MSS_CMD_ABS, 31'h00000000);
    cycles(2000);
    host_u.send(HLD);
    wait_mv(1'b0, 8000);
    move(MSS_CMD_ABS, 31'h00000190);
    wait_mv(1'b0, 30000);
    chk_pos(pos_q, 31'h00000190, "abandon end");
    chk_bit(stat_q.held, 1'b0, "abandon held");
    tdone("hold");
    move(MSS_CMD_REL, 31'h0000012C);
    cycles(50);
    jog_stop_in <= 1'b1;
    wait_mv(1'b0, 20000);
    chk_pos(pos_q, 31'h000002BC, "stop input ignored");
    jog_stop_in <= 1'b0;
    jog_cw <= 1'b1;
    jog_active <= 1'b1;
    move(MSS_CMD_JOG, 31'h00000000);
    cycles(1000);
    p0 = pos_q;
    cycles(200);
    chk_bit(pos_q > p0, 1'b1, "jog up");
    prof <= '{speed: 24'h03D090, accel: 16'h1000, decel: 16'h1000};
    cycles(600);
    p0 = pos_q;
    cycles(200);
    chk_bit(pos_q > p0 && pos_q - p0 < 31'h00000008, 1'b1, "jog new speed");
    jog_stop_in <= 1'b1;
    wait_mv(1'b0, 8000);
    chk_bit(stat_q.moving, 1'b0, "jog stop input");
    jog_stop_in <= 1'b0;
    jog_active <= 1'b0;
    tdone("jog");
    move(MSS_CMD_REL, 31'h0000012C);
    cycles(100);
    limit_cw <= 1'b1;
    wait_mv(1'b0, 4);
    chk_bit(stat_q.moving, 1'b0, "limit instant");
    chk_bit(stat_q.latched_err, 1'b1, "err latched");
    try_ref(MSS_CMD_REL);
    chk_bit(seen, 1'b1, "refused after limit");
    host_u.send(CLR);
    jog_active <= 1'b1;
    try_ref(MSS_CMD_JOG);
    chk_bit(seen, 1'b1, "jog into limit");
    jog_cw <= 1'b0;
    move(MSS_CMD_JOG, 31'h00000000);
    chk_bit(stat_q.moving, 1'b1, "jog off limit");
    jog_active <= 1'b0;
    wait_mv(1'b0, 8000);
    limit_cw <= 1'b0;
    tdone("limit");
    jog_cw <= 1'b1;
    jog_active <= 1'b1;
    move(MSS_CMD_JOG, 31'h00000000);
    cycles(1000);
    istop_rate <= ISTOP_RATE_MIN;
    host_u.send(IST);
    cycles(20);
    chk_bit(stat_q.moving, 1'b1, "istop ramps");
    stall <= 1'b1;
    wait_mv(1'b0, 8000);
    chk_bit(stat_q.motor_en, 1'b0, "stall motor off");
    chk_bit(stat_q.pos_invalid, 1'b1, "stall fault");
    {jog_active, stall} <= 2'b00;
    istop_rate <= ISTOP_RATE_RST;
    do_reset();
    move(MSS_CMD_REL, 31'h000003E8);
    cycles(500);
    host_u.send(IST);
    wait_mv(1'b0, 4);
    chk_bit(stat_q.motor_en, 1'b1, "istop clean");
    move(MSS_CMD_REL, 31'h000003E8);
    cycles(500);
    pos_err_over <= 1'b1;
    host_u.send(IST);
    cycles(4);
    chk_bit(stat_q.pos_invalid, 1'b1, "pos err fault");
    pos_err_over <= 1'b0;
    do_reset();
    move(MSS_CMD_REL, 31'h000003E8);
    cycles(500);
    estop_in <= 1'b1;
    wait_mv(1'b0, 4);
    estop_in <= 1'b0;
    host_u.send(RES);
    cycles(4);
    chk_bit(stat_q.moving, 1'b0, "estop no resume");
    try_ref(MSS_CMD_REL);
    chk_bit(seen, 1'b1, "refused after estop");
    host_u.send(CLR);
    move(MSS_CMD_REL, 31'h00000064);
    chk_bit(stat_q.moving, 1'b1, "move after clear");
    wait_mv(1'b0, 20000);
    tdone("istop");
    complete_run();
  end
endmodule
`default_nettype wire
